// ==== src/dwr_watchdog.sv ====
// Four-channel discrete output watchdog with auto-refresh behind a Wishbone slave.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`include "dwr_defs.svh"

module dwr_watchdog #(
    parameter int TICK_CYC    = `DWR_TICK_CYC,
    parameter int REFRESH_CYC = `DWR_REFRESH_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [5:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire dwr_pkg::dwr_ch_t      din,
    output dwr_pkg::dwr_ch_t           dout,
    output dwr_pkg::dwr_ch_t           dout_strobe,
    output logic                       irq
);
    // Register state.
    logic [31:0]        dat_q;
    logic [31:0]        dat_d;
    logic               ack_q;
    logic               ack_d;
    dwr_pkg::dwr_ch_t   out_q;
    dwr_pkg::dwr_ch_t   out_d;
    dwr_pkg::dwr_ch_t   wds_q;
    dwr_pkg::dwr_ch_t   wds_d;
    logic [1:0]         ctrl_q;
    logic [1:0]         ctrl_d;
    dwr_pkg::dwr_ch_t   mask_q;
    dwr_pkg::dwr_ch_t   mask_d;
    dwr_pkg::dwr_ch_t   stat_q;
    dwr_pkg::dwr_ch_t   stat_d;
    logic               irq_q;
    logic               irq_d;
    // Timing state.
    logic [31:0]        pre_q;
    logic [31:0]        pre_d;
    logic [31:0]        ref_q;
    logic [31:0]        ref_d;

    // Decoded request and per-channel results.
    logic               req;
    logic               wr0;
    logic               wr1;
    logic               sel_out;
    logic               sel_in;
    logic               sel_ctrl;
    logic               sel_wds;
    logic               sel_stat;
    logic               sel_mask;
    logic               sel_tmo;
    logic               tick;
    logic               refresh;
    wire  [3:0]         drv_all;
    wire  [3:0]         stb_all;
    wire  [3:0]         expire_all;
    wire  [63:0]        tmo_all;

    // Ack only on a fresh request so the one-cycle gap after ack is never a second access.
    assign req     = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr0     = req && wb_we_i && wb_sel_i[0];
    assign wr1     = req && wb_we_i && wb_sel_i[1];
    assign tick    = (pre_q == 32'(TICK_CYC - 1));
    assign refresh = (ref_q == 32'(REFRESH_CYC - 1));

    always_comb begin
        sel_out  = 1'b0;
        sel_in   = 1'b0;
        sel_ctrl = 1'b0;
        sel_wds  = 1'b0;
        sel_stat = 1'b0;
        sel_mask = 1'b0;
        sel_tmo  = 1'b0;
        if (req && wb_adr_i == `DWR_ADR_OUT) begin
            sel_out = 1'b1;
        end else if (req && wb_adr_i == `DWR_ADR_IN) begin
            sel_in = 1'b1;
        end else if (req && wb_adr_i == `DWR_ADR_CTRL) begin
            sel_ctrl = 1'b1;
        end else if (req && wb_adr_i == `DWR_ADR_WDSTATE) begin
            sel_wds = 1'b1;
        end else if (req && wb_adr_i == `DWR_ADR_STAT) begin
            sel_stat = 1'b1;
        end else if (req && wb_adr_i == `DWR_ADR_MASK) begin
            sel_mask = 1'b1;
        end else if (req && wb_adr_i >= `DWR_ADR_TMO0 && wb_adr_i <= `DWR_ADR_TMO3) begin
            sel_tmo = 1'b1;
        end
    end

    always_comb begin
        ack_d = req;
        dat_d = 32'h0000_0000;
        if (sel_out) begin
            dat_d = {28'h000_0000, drv_all};
        end else if (sel_in) begin
            dat_d = {28'h000_0000, din ^ {4{ctrl_q[`DWR_CTRL_INVERT]}}};
        end else if (sel_ctrl) begin
            dat_d = {30'h0, ctrl_q};
        end else if (sel_wds) begin
            dat_d = {28'h000_0000, wds_q};
        end else if (sel_stat) begin
            dat_d = {28'h000_0000, stat_q};
        end else if (sel_mask) begin
            dat_d = {28'h000_0000, mask_q};
        end else if (sel_tmo) begin
            dat_d = {16'h0000, tmo_all[16*wb_adr_i[1:0] +: 16]};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    always_comb begin
        out_d = out_q;
        if (sel_out && wr0) begin
            out_d = wb_dat_i[3:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_q <= `DWR_RST_CH;
        end else begin
            out_q <= out_d;
        end
    end

    always_comb begin
        wds_d = wds_q;
        if (sel_wds && wr0) begin
            wds_d = wb_dat_i[3:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wds_q <= `DWR_RST_CH;
        end else begin
            wds_q <= wds_d;
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        if (sel_ctrl && wr0) begin
            ctrl_d = wb_dat_i[1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `DWR_RST_CTRL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_comb begin
        mask_d = mask_q;
        if (sel_mask && wr0) begin
            mask_d = wb_dat_i[3:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_q <= `DWR_RST_CH;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_comb begin
        stat_d = stat_q;
        if (sel_stat && wr0) begin
            stat_d = stat_q & ~wb_dat_i[3:0];
        end
        // Set wins over a clear in the same cycle, so no expiry is ever lost.
        stat_d = stat_d | expire_all;
        irq_d  = |(stat_d & mask_d);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stat_q <= `DWR_RST_CH;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= irq_d;
        end
    end

    always_comb begin
        pre_d = tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= pre_d;
        end
    end

    always_comb begin
        ref_d = refresh ? 32'h0000_0000 : ref_q + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_q <= 32'h0000_0000;
        end else begin
            ref_q <= ref_d;
        end
    end

    for (genvar i = 0; i < `DWR_NUM_CH; i++) begin : g_ch
        dwr_pkg::dwr_tmo_t tmo_q;
        dwr_pkg::dwr_tmo_t tmo_d;
        dwr_pkg::dwr_tmo_t cnt_q;
        dwr_pkg::dwr_tmo_t cnt_d;
        logic              off;
        logic              own;
        logic              fire;
        logic              exp_q;
        logic              exp_d;
        logic              drv_q;
        logic              drv_d;
        logic              stb_q;
        logic              stb_d;

        assign off  = (tmo_q == `DWR_TMO_OFF0) || (tmo_q == `DWR_TMO_OFF1);
        assign own  = sel_out || (sel_tmo && wb_adr_i[1:0] == 2'(i));
        assign fire = !off && !own && tick && !exp_q && (cnt_q + 16'h0001 >= tmo_q);

        always_comb begin
            tmo_d = tmo_q;
            if (sel_tmo && wb_adr_i[1:0] == 2'(i) && wr0) begin
                tmo_d[7:0] = wb_dat_i[7:0];
            end
            if (sel_tmo && wb_adr_i[1:0] == 2'(i) && wr1) begin
                tmo_d[15:8] = wb_dat_i[15:8];
            end
        end

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                tmo_q <= `DWR_RST_TMO;
            end else begin
                tmo_q <= tmo_d;
            end
        end

        always_comb begin
            cnt_d = cnt_q;
            exp_d = exp_q;
            if (off) begin
                cnt_d = 16'h0000;
                exp_d = 1'b0;
            end else if (own) begin
                cnt_d = 16'h0000;
                exp_d = 1'b0;
            end else if (fire) begin
                exp_d = 1'b1;
            end else if (tick && !exp_q) begin
                cnt_d = cnt_q + 16'h0001;
            end
            // The channel picks between its programmed and its watchdog state.
            drv_d = exp_d ? wds_q[i] : out_d[i];
            stb_d = fire;
            if (sel_out && wr0) begin
                stb_d = 1'b1;
            end
            if (refresh && ctrl_q[`DWR_CTRL_REFRESH]) begin
                stb_d = 1'b1;
            end
        end

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cnt_q <= `DWR_RST_TMO;
                exp_q <= 1'b0;
                drv_q <= 1'b0;
                stb_q <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                exp_q <= exp_d;
                drv_q <= drv_d;
                stb_q <= stb_d;
            end
        end

        assign drv_all[i]          = drv_q;
        assign stb_all[i]          = stb_q;
        assign expire_all[i]       = fire;
        assign tmo_all[16*i +: 16] = tmo_q;
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = dat_q;
    assign dout        = drv_all;
    assign dout_strobe = stb_all;
    assign irq         = irq_q;
endmodule // dwr_watchdog

// ==== shared/dwr_defs.svh ====
// Register offsets, field positions, reset values and timing counts for the output watchdog.
// Overview of operation
// - Four channels, each with own watchdog settings.
// - Timeout programmable 1 to 65534 seconds.
// - Timeout 0 or 65535 disables watchdog.
// - Read or write of the output register or of the channel's own timeout register restarts count.
// - Expiry drives output to watchdog state.
// - Auto-refresh periodically rewrites programmed output state; here an expired channel is re-strobed with its watchdog state instead.
// - Refresh re-asserts command, recovering latched shutdown.
// - Writing one always switches output on.
// - Inversion affects sensed inputs only.
`ifndef DWR_DEFS_SVH
`define DWR_DEFS_SVH

`define DWR_NUM_CH          4
`define DWR_ADR_OUT         6'h00
`define DWR_ADR_IN          6'h01
`define DWR_ADR_CTRL        6'h02
`define DWR_ADR_WDSTATE     6'h03
`define DWR_ADR_STAT        6'h04
`define DWR_ADR_MASK        6'h05
`define DWR_ADR_TMO0        6'h08
`define DWR_ADR_TMO3        6'h0B
`define DWR_CTRL_REFRESH    0
`define DWR_CTRL_INVERT     1
`define DWR_TMO_OFF0        16'h0000
`define DWR_TMO_OFF1        16'hFFFF
`define DWR_CLK_HZ          200000000
`define DWR_TICK_S          1
`define DWR_TICK_CYC        (`DWR_CLK_HZ * `DWR_TICK_S)
`define DWR_REFRESH_MS      100
`define DWR_REFRESH_CYC     (`DWR_CLK_HZ / 1000 * `DWR_REFRESH_MS)
`define DWR_PULSE_CYC       4
`define DWR_RST_CH          4'h0
`define DWR_RST_CTRL        2'h0
`define DWR_RST_TMO         16'h0000

`endif

// ==== shared/dwr_pkg.sv ====
// Types shared by the output watchdog block.
package dwr_pkg;
    typedef logic [15:0] dwr_tmo_t;
    typedef logic [3:0]  dwr_ch_t;
endpackage

// ==== verification/dwr_watchdog_checker.sv ====
// Port-level assertions for the output watchdog.
module dwr_watchdog_checker #(
    parameter int TICK_CYC    = 10,
    parameter int REFRESH_CYC = 16
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  dout,
    input wire logic [3:0]  dout_strobe,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_wr_q;
    logic seen_wr_d;
    always_comb seen_wr_d = seen_wr_q | (wb_ack_o & wb_we_i);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) seen_wr_q <= 1'b0;
        else seen_wr_q <= seen_wr_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_delay_a: assert property ($rose(wb_stb_i) |=> wb_ack_o) else $error("late ack");
    out_write_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 6'h00
        |-> dout == wb_dat_i[3:0] && dout_strobe == 4'hF) else $error("write of outputs");
    hole_read_a: assert property (wb_ack_o && !wb_we_i && (wb_adr_i inside {6'h06, 6'h07}
        || wb_adr_i > 6'h0B) |-> wb_dat_o == 32'h0) else $error("hole read");
    dout_cause_a: assert property ($changed(dout) && !wb_ack_o
        |-> dout_strobe != 4'h0) else $error("output moved without strobe");
    quiet_start_a: assert property (!seen_wr_d
        |-> dout_strobe == 4'h0 && !irq && dout == 4'h0) else $error("activity unconfigured");
    ro_write_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 6'h01
        && dout_strobe == 4'h0 |-> $stable(dout)) else $error("input write moved output");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
    cover property (dout_strobe == 4'hF && !wb_ack_o);
    cover property ($rose(irq));
    cover property (wb_ack_o && wb_we_i && wb_adr_i == 6'h08);
endmodule // dwr_watchdog_checker

bind dwr_watchdog dwr_watchdog_checker #(.TICK_CYC(TICK_CYC), .REFRESH_CYC(REFRESH_CYC))
    checker_inst (.ref_clk(ref_clk), .rst(rst), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dout(dout), .dout_strobe(dout_strobe), .irq(irq));

// ==== verification/dwr_field.sv ====
// Field-side model driving the sensed inputs.
module dwr_field (
    input  wire logic             ref_clk,
    input  wire dwr_pkg::dwr_ch_t level,
    output dwr_pkg::dwr_ch_t      din
);
    timeunit 1ns;
    timeprecision 1ps;
    initial din = 4'h0;
    // Field levels are registered so the block never sees them move on its sampling edge.
    always @(posedge ref_clk) din <= level;
endmodule // dwr_field

// ==== verification/tb_dwr_watchdog.sv ====
// Self-checking bench for the output watchdog.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    $display("unexpected %s expected %h seen %h", nm, e, g); n_errors++; end end
module tb_dwr_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    logic             ref_clk = 1'b0;
    logic             rst = 1'b1;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [5:0]       adr = 6'h00;
    logic [31:0]      dat = 32'h0;
    logic [31:0]      rdat;
    logic             ack;
    logic             irq;
    dwr_pkg::dwr_ch_t din;
    dwr_pkg::dwr_ch_t dout;
    dwr_pkg::dwr_ch_t dstb;
    dwr_pkg::dwr_ch_t level = 4'h0;
    int               n_errors = 0;
    int               n_compared = 0;
    int               cycles = 0;
    dwr_watchdog #(.TICK_CYC(10), .REFRESH_CYC(16)) dwr_watchdog_inst (.ref_clk(ref_clk),
        .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .din(din),
        .dout(dout), .dout_strobe(dstb), .irq(irq));
    dwr_field dwr_field_inst (.ref_clk(ref_clk), .level(level), .din(din));
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge ref_clk);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic t_out;
        logic [31:0] q;
        wb(1'b1, 6'h00, 32'h5, q);
        `CHK("dout", 4'h5, dout)
        wb(1'b0, 6'h06, 32'h0, q);
        `CHK("hole", 32'h0, q)
        level <= 4'h6;
        wb(1'b1, 6'h02, 32'h2, q);
        wb(1'b0, 6'h01, 32'h0, q);
        `CHK("inverted inputs", 32'h9, q)
        wb(1'b1, 6'h01, 32'hF, q);
        `CHK("dout", 4'h5, dout)
        $display("t_out done");
    endtask
    task automatic t_wdog;
        logic [31:0] q;
        wb(1'b1, 6'h03, 32'h0, q);
        wb(1'b1, 6'h00, 32'hF, q);
        wb(1'b1, 6'h05, 32'h1, q);
        wb(1'b1, 6'h08, 32'h2, q);
        // Reads of the outputs come faster than one tick, so the count must keep restarting.
        repeat (5) begin
            repeat (6) @(posedge ref_clk);
            wb(1'b0, 6'h00, 32'h0, q);
        end
        `CHK("kept", 4'hF, dout)
        repeat (22) @(posedge ref_clk);
        `CHK("expired", 4'hE, dout)
        `CHK("irq", 1'b1, irq)
        wb(1'b0, 6'h04, 32'h0, q);
        `CHK("status", 32'h1, q)
        wb(1'b1, 6'h08, 32'hFFFF, q);
        `CHK("restored", 4'hF, dout)
        wb(1'b1, 6'h05, 32'h0, q);
        repeat (2) @(posedge ref_clk);
        `CHK("masked irq", 1'b0, irq)
        wb(1'b1, 6'h04, 32'hF, q);
        wb(1'b1, 6'h05, 32'h1, q);
        repeat (30) @(posedge ref_clk);
        `CHK("disabled", 1'b0, irq)
        $display("t_wdog done");
    endtask
    task automatic t_refresh;
        logic [31:0] q;
        int          n;
        for (int e = 1; e >= 0; e--) begin
            wb(1'b1, 6'h02, 32'(e), q);
            n = 0;
            repeat (64) begin
                @(negedge ref_clk);
                if (dstb === 4'hF) n++;
            end
            `CHK("refresh count", 4 * e, n)
            `CHK("dout", 4'hF, dout)
        end
        $display("t_refresh done");
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_out();
        t_wdog();
        t_refresh();
        report_and_stop();
    end
endmodule // tb_dwr_watchdog
